// >>> shared/btc_regs.svh
// Register offsets, field positions, reset values and timing counts
// of the burst trigger controller. Assumes a 32-bit APB register bus.
`ifndef BTC_REGS_SVH
`define BTC_REGS_SVH
`define BTC_OFF_CTRL    12'h000
`define BTC_OFF_CYCLES  12'h004
`define BTC_OFF_PERIOD  12'h008
`define BTC_OFF_PHASE   12'h00C
`define BTC_OFF_CMD     12'h010
`define BTC_OFF_STATUS  12'h014
`define BTC_CTRL_SRC_LO 0
`define BTC_CTRL_GATED  2
`define BTC_CTRL_TSLOPE 3
`define BTC_CTRL_OUTEN  4
`define BTC_CTRL_OSLOPE 5
`define BTC_CTRL_SHP_LO 6
`define BTC_CTRL_REMOTE 9
`define BTC_CTRL_BURST  10
`define BTC_CTRL_GINV   11
`define BTC_CMD_BUSTRIG 0
`define BTC_CMD_APPLY   1
`define BTC_CTRL_RST    12'h000
`define BTC_CYCLES_RST  16'h0001
`define BTC_PHASE_MAX   360
`define BTC_PULSE_NS    1000
`define BTC_CLK_MHZ     100
`define BTC_PULSE_CYC   ((`BTC_PULSE_NS * `BTC_CLK_MHZ) / 1000 + 1)
`define BTC_PERIOD_RST  1000000
`endif

// >>> shared/btc_pkg.sv
// Types shared by the burst trigger controller modules.
// Assumes btc_regs.svh supplies the numeric constants.
`default_nettype none
package btc_pkg;
  typedef enum logic [1:0] {
    BTC_SRC_INT = 2'h0, BTC_SRC_EXT = 2'h1,
    BTC_SRC_MAN = 2'h2, BTC_SRC_BUS = 2'h3
  } btc_src_t;
  typedef enum logic [2:0] {
    BTC_SHP_SINE = 3'h0, BTC_SHP_SQUARE = 3'h1, BTC_SHP_RAMP = 3'h2,
    BTC_SHP_PULSE = 3'h3, BTC_SHP_NOISE = 3'h4, BTC_SHP_ARB = 3'h5
  } btc_shape_t;
  typedef enum logic [3:0] {
    BTC_ST_IDLE  = 4'h1, BTC_ST_BURST = 4'h2,
    BTC_ST_GATE  = 4'h4, BTC_ST_DRAIN = 4'h8
  } btc_state_t;
endpackage : btc_pkg
`default_nettype wire

// >>> rtl/btc_sync.sv
// Three-stage synchroniser for a pin input.
// Assumes the pin is asynchronous to mclk; output moves once stages agree.
`default_nettype none
module btc_sync (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic pinIn,
  output logic      level
);
  logic s1;
  logic s2;
  logic s3;

  // Shift the pin through three stages; only stage two reads stage one.
  always_ff @(posedge mclk) begin
    if (rst) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= pinIn;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Accept a new level only when the last two stages agree.
  always_ff @(posedge mclk) begin
    if (rst) begin
      level <= 1'b0;
    end else if (s2 == s3) begin
      level <= s3;
    end
  end
endmodule : btc_sync
`default_nettype wire

// >>> rtl/btc_pulse.sv
// Fixed-width pulse stretcher for the trigger output.
// Assumes start is a one-cycle pulse on mclk.
`default_nettype none
module btc_pulse #(
  parameter int WIDTH = 101
) (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic start,
  output logic      busy
);
  logic [15:0] left;

  // Load the width on start and count down to zero.
  always_ff @(posedge mclk) begin
    if (rst) begin
      left <= 16'h0000;
    end else if (start) begin
      left <= 16'(WIDTH);
    end else if (left != 16'h0000) begin
      left <= left - 16'h0001;
    end
  end

  assign busy = (left != 16'h0000);
endmodule : btc_pulse
`default_nettype wire

// >>> rtl/btc_top.sv
// Burst trigger controller: source select, burst sequencing, start phase,
// gated hold and trigger output. Assumes an APB master on mclk and a
// waveform engine that pulses cycleEnd at the end of each output cycle.
//
// Design decisions made here: register access over APB and the placing of the registers.
`include "btc_regs.svh"
`default_nettype none
module btc_top
  import btc_pkg::*;
#(
  parameter int DEF_PERIOD = `BTC_PERIOD_RST
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  input  wire logic        trigInPin,
  input  wire logic        keyPin,
  input  wire logic        cycleEnd,
  output logic             burstRun,
  output logic             holdAtPhase,
  output logic [9:0]       phaseOut,
  output logic             trigOut,
  output logic             trigOutEn,
  output logic             keyLamp
);
  localparam int PULSE_CYC = `BTC_PULSE_CYC;
  btc_state_t  state;
  btc_state_t  next_state;
  logic [11:0] ctrl;
  logic [15:0] cycles;
  logic [31:0] period;
  logic [9:0]  phase;
  logic [15:0] cycleCnt;
  logic [31:0] timer;
  logic        trigLvl, trigLvlD, keyLvl, keyLvlD;
  logic        pulseBusy, sqHigh, busTrig, applyCmd;
  logic        wrEn, mapped, timerTick, extEdge;
  logic        keyStart, startReq, lastCycle, gateTrue;
  btc_src_t    src;
  btc_shape_t  shape;
  // Decode an APB address into a mapped flag.
  function automatic logic isMapped(input logic [11:0] a);
    return a == `BTC_OFF_CTRL || a == `BTC_OFF_CYCLES ||
           a == `BTC_OFF_PERIOD || a == `BTC_OFF_PHASE ||
           a == `BTC_OFF_CMD || a == `BTC_OFF_STATUS;
  endfunction : isMapped
  // Pin inputs pass the three-stage synchroniser.
  btc_sync uTrigSync (
    .mclk  (mclk),
    .rst   (rst),
    .pinIn (trigInPin),
    .level (trigLvl)
  );
  btc_sync uKeySync (
    .mclk  (mclk),
    .rst   (rst),
    .pinIn (keyPin),
    .level (keyLvl)
  );
  // Field views of the control register.
  assign src      = btc_src_t'(ctrl[`BTC_CTRL_SRC_LO +: 2]);
  assign shape    = btc_shape_t'(ctrl[`BTC_CTRL_SHP_LO +: 3]);
  assign gateTrue = trigLvl ^ ctrl[`BTC_CTRL_GINV];
  // APB slave answers with no wait state and flags unmapped addresses.
  assign mapped  = isMapped(paddr);
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign wrEn    = psel & penable & pwrite & mapped;
  assign busTrig = wrEn & (paddr == `BTC_OFF_CMD) & pwdata[`BTC_CMD_BUSTRIG];
  assign applyCmd = wrEn & (paddr == `BTC_OFF_CMD) & pwdata[`BTC_CMD_APPLY];
  // Control register: source falls back to internal on reset or setup command.
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl <= `BTC_CTRL_RST;
    end else if (wrEn && paddr == `BTC_OFF_CTRL) begin
      ctrl <= pwdata[11:0];
    end else if (applyCmd) begin
      ctrl[`BTC_CTRL_SRC_LO +: 2] <= BTC_SRC_INT;
    end
  end
  // Burst count and burst period; a zero count means an endless burst.
  always_ff @(posedge mclk) begin
    if (rst) begin
      cycles <= `BTC_CYCLES_RST;
      period <= 32'(DEF_PERIOD);
    end else if (wrEn && paddr == `BTC_OFF_CYCLES) begin
      cycles <= pwdata[15:0];
    end else if (wrEn && paddr == `BTC_OFF_PERIOD && pwdata != 32'h0) begin
      period <= pwdata;
    end
  end
  // Start phase in signed degrees; out-of-range writes are refused.
  always_ff @(posedge mclk) begin
    if (rst) begin
      phase <= 10'h000;
    end else if (wrEn && paddr == `BTC_OFF_PHASE &&
                 $signed(pwdata) >= -`BTC_PHASE_MAX &&
                 $signed(pwdata) <= `BTC_PHASE_MAX) begin
      phase <= pwdata[9:0];
    end
  end
  // Read data is captured in the setup cycle and held for the access.
  always_ff @(posedge mclk) begin
    if (rst) begin
      prdata <= 32'h0;
    end else if (psel && !penable) begin
      case (paddr)
        `BTC_OFF_CTRL:   prdata <= {20'h0, ctrl};
        `BTC_OFF_CYCLES: prdata <= {16'h0, cycles};
        `BTC_OFF_PERIOD: prdata <= period;
        `BTC_OFF_PHASE:  prdata <= {{22{phase[9]}}, phase};
        `BTC_OFF_STATUS: prdata <= {24'h0, keyLamp, trigOut, state, burstRun, holdAtPhase};
        default:         prdata <= 32'h0;
      endcase
    end
  end
  // Period counter runs only for the internal source in triggered mode.
  always_ff @(posedge mclk) begin
    if (rst) begin
      timer <= 32'h1;
    end else if (src != BTC_SRC_INT || ctrl[`BTC_CTRL_GATED] ||
                 !ctrl[`BTC_CTRL_BURST]) begin
      timer <= 32'h1;
    end else if (timer <= 32'h1) begin
      timer <= period;
    end else begin
      timer <= timer - 32'h1;
    end
  end
  assign timerTick = src == BTC_SRC_INT && !ctrl[`BTC_CTRL_GATED] &&
                     ctrl[`BTC_CTRL_BURST] && timer <= 32'h1;
  assign sqHigh    = timer > (period >> 1);
  // Edge memories for the trigger pin and the key.
  always_ff @(posedge mclk) begin
    if (rst) begin
      trigLvlD <= 1'b0;
      keyLvlD  <= 1'b0;
    end else begin
      trigLvlD <= trigLvl;
      keyLvlD  <= keyLvl;
    end
  end
  assign extEdge = ctrl[`BTC_CTRL_TSLOPE] ? (trigLvlD & ~trigLvl)
                                          : (~trigLvlD & trigLvl);
  assign keyStart = keyLvl & ~keyLvlD & ~ctrl[`BTC_CTRL_REMOTE] &
                    ctrl[`BTC_CTRL_BURST];
  // Pick the start request of the selected source.
  always_comb begin
    case (src)
      BTC_SRC_INT: startReq = timerTick;
      BTC_SRC_EXT: startReq = extEdge;
      BTC_SRC_MAN: startReq = keyStart;
      BTC_SRC_BUS: startReq = busTrig;
      default:     startReq = 1'b0;
    endcase
  end
  // A finite burst ends on the cycle end of its last counted cycle.
  assign lastCycle = cycleEnd && cycles != 16'h0 && cycleCnt + 16'h1 >= cycles;
  // Burst sequencer; starts are accepted only while idle.
  always_comb begin
    next_state = state;
    case (state)
      BTC_ST_IDLE: begin
        if (!ctrl[`BTC_CTRL_BURST]) begin
          next_state = BTC_ST_IDLE;
        end else if (ctrl[`BTC_CTRL_GATED]) begin
          if (gateTrue) begin
            next_state = BTC_ST_GATE;
          end
        end else if (startReq) begin
          next_state = BTC_ST_BURST;
        end
      end
      BTC_ST_BURST: begin
        if (lastCycle || !ctrl[`BTC_CTRL_BURST]) begin
          next_state = BTC_ST_IDLE;
        end
      end
      BTC_ST_GATE: begin
        if (!gateTrue || !ctrl[`BTC_CTRL_GATED]) begin
          next_state = (shape == BTC_SHP_NOISE) ? BTC_ST_IDLE : BTC_ST_DRAIN;
        end
      end
      BTC_ST_DRAIN: begin
        if (cycleEnd) begin
          next_state = BTC_ST_IDLE;
        end
      end
      default: next_state = BTC_ST_IDLE;
    endcase
  end
  // State register.
  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= BTC_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end
  // Cycle counter cleared at each start; extra edges leave it alone.
  always_ff @(posedge mclk) begin
    if (rst) begin
      cycleCnt <= 16'h0;
    end else if (state == BTC_ST_IDLE) begin
      cycleCnt <= 16'h0;
    end else if (state == BTC_ST_BURST && cycleEnd) begin
      cycleCnt <= cycleCnt + 16'h1;
    end
  end

  // Engine outputs: run, hold and effective start phase.
  always_ff @(posedge mclk) begin
    if (rst) begin
      burstRun    <= 1'b0;
      holdAtPhase <= 1'b1;
      phaseOut    <= 10'h000;
    end else begin
      burstRun    <= next_state == BTC_ST_BURST || next_state == BTC_ST_GATE ||
                     next_state == BTC_ST_DRAIN;
      holdAtPhase <= next_state == BTC_ST_IDLE;
      phaseOut    <= (shape == BTC_SHP_PULSE || shape == BTC_SHP_NOISE) ? 10'h000
                                                                         : phase;
    end
  end

  // Trigger output pulse for manual and bus sources.
  btc_pulse #(
    .WIDTH (PULSE_CYC)
  ) uPulse (
    .mclk  (mclk),
    .rst   (rst),
    .start (state == BTC_ST_IDLE && next_state == BTC_ST_BURST &&
            (src == BTC_SRC_MAN || src == BTC_SRC_BUS)),
    .busy  (pulseBusy)
  );

  // Trigger output level, polarity and enable; lamp shows armed state.
  always_ff @(posedge mclk) begin
    if (rst) begin
      trigOut   <= 1'b0;
      trigOutEn <= 1'b0;
      keyLamp   <= 1'b0;
    end else begin
      trigOutEn <= ctrl[`BTC_CTRL_OUTEN] && src != BTC_SRC_EXT;
      if (!ctrl[`BTC_CTRL_OUTEN] || src == BTC_SRC_EXT) begin
        trigOut <= 1'b0;
      end else if (src == BTC_SRC_INT) begin
        trigOut <= sqHigh ^ ctrl[`BTC_CTRL_OSLOPE];
      end else begin
        trigOut <= pulseBusy ^ ctrl[`BTC_CTRL_OSLOPE];
      end
      keyLamp <= state == BTC_ST_IDLE && !ctrl[`BTC_CTRL_GATED] &&
                 ctrl[`BTC_CTRL_BURST] && !ctrl[`BTC_CTRL_REMOTE] &&
                 (src == BTC_SRC_MAN || src == BTC_SRC_BUS);
    end
  end

  // Checks on the sequencing and outputs.
  sequence s_busStart;
    state == BTC_ST_IDLE && src == BTC_SRC_BUS && busTrig &&
    ctrl[`BTC_CTRL_BURST] && !ctrl[`BTC_CTRL_GATED];
  endsequence
  property p_rstSrc;
    @(posedge mclk) rst |=> src == BTC_SRC_INT && phase == 10'h000;
  endproperty
  a_rstSrc: assert property (p_rstSrc) else $error("Reset state wrong.");
  property p_apply;
    @(posedge mclk) disable iff (rst)
      applyCmd && !(paddr == `BTC_OFF_CTRL) |=> src == BTC_SRC_INT;
  endproperty
  a_apply: assert property (p_apply) else $error("Setup left source.");
  property p_extOff;
    @(posedge mclk) disable iff (rst) src == BTC_SRC_EXT |=> !trigOutEn && !trigOut;
  endproperty
  a_extOff: assert property (p_extOff) else $error("Trigger out live.");
  property p_noRestart;
    @(posedge mclk) disable iff (rst)
      state == BTC_ST_BURST && extEdge && !cycleEnd && ctrl[`BTC_CTRL_BURST] |=>
      state == BTC_ST_BURST && cycleCnt == $past(cycleCnt);
  endproperty
  a_noRestart: assert property (p_noRestart) else $error("Burst restarted.");
  property p_done;
    @(posedge mclk) disable iff (rst)
      state == BTC_ST_BURST && lastCycle |=> state == BTC_ST_IDLE && holdAtPhase && !burstRun;
  endproperty
  a_done: assert property (p_done) else $error("Burst overran.");
  property p_drain;
    @(posedge mclk) disable iff (rst)
      state == BTC_ST_DRAIN && cycleEnd |=> holdAtPhase && !burstRun;
  endproperty
  a_drain: assert property (p_drain) else $error("Gate not held.");
  property p_phaseIgn;
    @(posedge mclk) disable iff (rst)
      shape == BTC_SHP_PULSE || shape == BTC_SHP_NOISE |=> phaseOut == 10'h000;
  endproperty
  a_phaseIgn: assert property (p_phaseIgn) else $error("Phase applied.");
  property p_busPulse;
    @(posedge mclk) disable iff (rst)
      s_busStart ##1 ctrl[`BTC_CTRL_OUTEN] |=> pulseBusy[*8];
  endproperty
  a_busPulse: assert property (p_busPulse) else $error("Pulse too short.");
  property p_keyLock;
    @(posedge mclk) disable iff (rst)
      state == BTC_ST_IDLE && src == BTC_SRC_MAN && !ctrl[`BTC_CTRL_GATED] &&
      (ctrl[`BTC_CTRL_REMOTE] || !ctrl[`BTC_CTRL_BURST]) |=> state == BTC_ST_IDLE;
  endproperty
  a_keyLock: assert property (p_keyLock) else $error("Key in remote.");
  property p_gateDrop;
    @(posedge mclk) disable iff (rst)
      state == BTC_ST_IDLE && ctrl[`BTC_CTRL_GATED] && !gateTrue |=>
      state == BTC_ST_IDLE;
  endproperty
  a_gateDrop: assert property (p_gateDrop) else $error("Gated start.");
endmodule : btc_top
`default_nettype wire

// >>> verif/btc_far_model.sv
// Far-side model: waveform engine, trigger connector and trigger key.
// Assumes the bench calls its tasks from the mclk domain.
`default_nettype none
module btc_far_model (
  input  wire logic       mclk,
  input  wire logic       burstRun,
  input  wire logic [3:0] gap,
  output logic            cycleEnd,
  output logic            trigInPin,
  output logic            keyPin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] phaseCnt;

  // Everything starts quiet, so the design never sees an unknown pin.
  initial begin
    phaseCnt  = 4'h0;
    cycleEnd  = 1'b0;
    trigInPin = 1'b0;
    keyPin    = 1'b0;
  end

  // Ends one output cycle every gap clocks, and only while a burst runs.
  always @(posedge mclk) begin
    cycleEnd <= burstRun && (phaseCnt == gap - 4'h1);
    if (!burstRun || phaseCnt == gap - 4'h1) begin
      phaseCnt <= 4'h0;
    end else begin
      phaseCnt <= phaseCnt + 4'h1;
    end
  end

  // Moves the trigger connector to a new level just after an edge.
  task automatic setTrig(input logic v);
    @(posedge mclk);
    trigInPin <= v;
  endtask : setTrig

  // One key press, long enough to pass the pin synchroniser.
  task automatic pressKey();
    @(posedge mclk);
    keyPin <= ~keyPin;
    repeat (10) @(posedge mclk);
    keyPin <= ~keyPin;
    repeat (10) @(posedge mclk);
  endtask : pressKey
endmodule : btc_far_model
`default_nettype wire

// >>> verif/test_burst_trigger_control.sv
// Self-checking bench of the burst trigger controller.
// Assumes btc_top, btc_far_model and btc_regs.svh are compiled alongside.
`include "btc_regs.svh"
`default_nettype none
module test_burst_trigger_control;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DEFP = 20;
  logic        mclk, rst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        trigInPin, keyPin, cycleEnd, burstRun, holdAtPhase;
  logic        trigOut, trigOutEn, keyLamp, lastRun, lastEnd, fellAfterEnd;
  logic [9:0]  phaseOut;
  logic [3:0]  gap;
  int          errTotal, samplesChecked, starts, ends, highCnt;
  time         lastRise, prevRise;

  btc_top #(.DEF_PERIOD(DEFP)) dut (.mclk(mclk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .prdata(prdata), .trigInPin(trigInPin),
    .keyPin(keyPin), .cycleEnd(cycleEnd), .burstRun(burstRun),
    .holdAtPhase(holdAtPhase), .phaseOut(phaseOut), .trigOut(trigOut),
    .trigOutEn(trigOutEn), .keyLamp(keyLamp));
  btc_far_model far (.mclk(mclk), .burstRun(burstRun), .gap(gap),
    .cycleEnd(cycleEnd), .trigInPin(trigInPin), .keyPin(keyPin));

  // Counts burst starts, cycle ends and trigger-out high cycles; notes burst ends.
  always @(posedge mclk) begin
    lastRun <= burstRun;
    lastEnd <= cycleEnd;
    if (burstRun === 1'b1 && lastRun !== 1'b1) begin
      starts++;
      prevRise = lastRise;
      lastRise = $time;
    end
    if (burstRun === 1'b0 && lastRun === 1'b1) begin
      fellAfterEnd = lastEnd;
    end
    if (burstRun === 1'b1 && cycleEnd === 1'b1) begin
      ends++;
    end
    if (trigOut === 1'b1) begin
      highCnt++;
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    samplesChecked++;
    if (got !== exp) begin
      errTotal++;
      $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  // One APB transfer; holds the request until pready is seen high.
  task automatic apbXfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                         output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge mclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge mclk);
      n++;
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    check({31'h0, pready}, 32'h1, "pready");
  endtask : apbXfer

  task automatic regWr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apbXfer(1'b1, a, d, r, e);
  endtask : regWr

  task automatic regRd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apbXfer(1'b0, a, 32'h0, r, e);
    check(r, exp, "read");
  endtask : regRd

  // Waits a bounded time for burstRun to reach a level.
  task automatic waitRun(input logic v, input int n);
    int k;
    k = 0;
    while (burstRun !== v && k < n) begin
      @(negedge mclk);
      k++;
    end
    check({31'h0, burstRun}, {31'h0, v}, "burstRun");
  endtask : waitRun

  task automatic testReset();
    logic [31:0] r;
    logic        e;
    regRd(`BTC_OFF_CTRL, 32'h0);
    regRd(`BTC_OFF_CYCLES, 32'h1);
    regRd(`BTC_OFF_PERIOD, DEFP);
    regRd(`BTC_OFF_PHASE, 32'h0);
    regRd(`BTC_OFF_STATUS, 32'h5);
    apbXfer(1'b0, 12'h018, 32'h0, r, e);
    check({31'h0, e}, 32'h1, "slverr");
    check(r, 32'h0, "unmapped data");
    $display("reset test done");
  endtask : testReset

  task automatic testPhase();
    logic [31:0] shp [2];
    shp = '{32'h0C0, 32'h100};
    regWr(`BTC_OFF_PHASE, 32'hFFFFFE98);
    regRd(`BTC_OFF_PHASE, 32'hFFFFFE98);
    regWr(`BTC_OFF_PHASE, 32'h169);
    regRd(`BTC_OFF_PHASE, 32'hFFFFFE98);
    repeat (3) @(negedge mclk);
    check({22'h0, phaseOut}, 32'h298, "phase");
    regWr(`BTC_OFF_PHASE, 32'h168);
    foreach (shp[i]) begin
      regWr(`BTC_OFF_CTRL, shp[i]);
      repeat (3) @(negedge mclk);
      check({22'h0, phaseOut}, 32'h0, "phase");
    end
    regWr(`BTC_OFF_CTRL, 32'h140);
    repeat (3) @(negedge mclk);
    check({22'h0, phaseOut}, 32'h168, "phase");
    $display("phase test done");
  endtask : testPhase

  task automatic testBus();
    int s, n, h, cnt;
    cnt = 0;
    regWr(`BTC_OFF_CYCLES, 32'h3);
    regWr(`BTC_OFF_CTRL, 32'h413);
    repeat (3) @(negedge mclk);
    check({31'h0, keyLamp}, 32'h1, "lamp");
    s = starts;
    n = ends;
    h = highCnt;
    regWr(`BTC_OFF_CMD, 32'h1);
    regWr(`BTC_OFF_CMD, 32'h1);
    repeat (150) @(negedge mclk);
    check(highCnt - h, `BTC_PULSE_CYC, "pulse");
    check(starts - s, 1, "bursts");
    check(ends - n, 3, "cycles");
    check({31'h0, fellAfterEnd}, 32'h1, "stop");
    check({31'h0, holdAtPhase}, 32'h1, "hold");
    regWr(`BTC_OFF_CTRL, 32'h433);
    repeat (3) @(negedge mclk);
    check({31'h0, trigOut}, 32'h1, "idle high");
    regWr(`BTC_OFF_CMD, 32'h1);
    repeat (150) begin
      @(negedge mclk);
      cnt += (trigOut === 1'b0);
    end
    check(cnt, `BTC_PULSE_CYC, "low pulse");
    $display("bus test done");
  endtask : testBus

  task automatic testKey();
    int s;
    logic [31:0] c [3];
    c = '{32'h402, 32'h602, 32'h002};
    s = starts;
    foreach (c[i]) begin
      regWr(`BTC_OFF_CTRL, c[i]);
      far.pressKey();
      repeat (30) @(negedge mclk);
      check(starts - s, 1, "key bursts");
    end
    $display("key test done");
  endtask : testKey

  task automatic testExt();
    int s;
    gap <= gap + 4'h5;
    regWr(`BTC_OFF_CYCLES, 32'h2);
    regWr(`BTC_OFF_CTRL, 32'h411);
    repeat (3) @(negedge mclk);
    check({31'h0, trigOutEn}, 32'h0, "out en");
    s = starts;
    far.setTrig(1'b1);
    repeat (8) @(posedge mclk);
    far.setTrig(1'b0);
    repeat (4) @(posedge mclk);
    far.setTrig(1'b1);
    repeat (60) @(negedge mclk);
    check(starts - s, 1, "ext bursts");
    regWr(`BTC_OFF_CTRL, 32'h419);
    far.setTrig(1'b0);
    repeat (40) @(negedge mclk);
    check(starts - s, 2, "ext bursts");
    gap <= gap - 4'h5;
    $display("external test done");
  endtask : testExt

  task automatic testGate();
    int s;
    regWr(`BTC_OFF_CTRL, 32'h406);
    s = starts;
    far.pressKey();
    check(starts - s, 0, "gated key");
    far.setTrig(1'b1);
    waitRun(1'b1, 20);
    repeat (30) @(posedge mclk);
    far.setTrig(1'b0);
    waitRun(1'b0, 20);
    check({31'h0, fellAfterEnd}, 32'h1, "drain");
    check({31'h0, holdAtPhase}, 32'h1, "hold");
    regWr(`BTC_OFF_CTRL, 32'hD06);
    waitRun(1'b1, 20);
    far.setTrig(1'b1);
    waitRun(1'b0, 7);
    check({31'h0, holdAtPhase}, 32'h1, "hold");
    $display("gate test done");
  endtask : testGate

  task automatic testInt();
    int cnt;
    cnt = 0;
    regWr(`BTC_OFF_CTRL, 32'h413);
    regWr(`BTC_OFF_CMD, 32'h2);
    regRd(`BTC_OFF_CTRL, 32'h410);
    repeat (50) @(negedge mclk);
    repeat (40) begin
      @(negedge mclk);
      cnt += (trigOut === 1'b1);
    end
    check(cnt, 20, "square");
    check(32'(lastRise - prevRise), DEFP * 10, "spacing");
    regWr(`BTC_OFF_CTRL, 32'h0);
    $display("internal test done");
  endtask : testInt

  task automatic printVerdict();
    $display("checked %0d mismatches %0d", samplesChecked, errTotal);
    if (errTotal == 0 && samplesChecked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : printVerdict

  // Free-running 100 MHz clock.
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Cuts a hang short well beyond the expected run length.
  initial begin
    #100000;
    errTotal++;
    $display("[ERR] %0t watchdog expired", $time);
    printVerdict();
  end

  // Main sequence: reset for six cycles, then each scenario in turn.
  initial begin
    rst     = 1'b1;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
    gap     = 4'h4;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    testReset();
    testPhase();
    testBus();
    testKey();
    testExt();
    testGate();
    testInt();
    printVerdict();
  end
endmodule : test_burst_trigger_control
`default_nettype wire
